// ===== design/tlic_consts.svh
/*
  constants for the two-level interrupt controller: register offsets, field positions,
  reset values and vector addresses. assumes inclusion by bare name from design files.
*/
`ifndef TLIC_CONSTS_SVH
`define TLIC_CONSTS_SVH

`define TLIC_NSRC 7
`define TLIC_ADDR_W 4
// register offsets
`define TLIC_OFF_SOURCE_EN 4'h0
`define TLIC_OFF_LEVEL_SEL 4'h1
`define TLIC_OFF_TIMER_CTL 4'h2
`define TLIC_OFF_STATUS 4'h3
`define TLIC_OFF_MASK 4'h4
`define TLIC_OFF_SERVICE 4'h5
`define TLIC_OFF_IDLE 4'h6
// field positions
`define TLIC_GLOBAL_EN_BIT 7
`define TLIC_EXT0_TRIG_BIT 0
`define TLIC_EXT1_TRIG_BIT 2
// reset values
`define TLIC_RST_SOURCE_EN 8'h00
`define TLIC_RST_LEVEL_SEL 8'h00
`define TLIC_RST_TIMER_CTL 8'h00
`define TLIC_RST_MASK 8'h00
// vector addresses: base plus eight per polling position
`define TLIC_VEC_BASE 16'h0003
`define TLIC_VEC_STEP 16'h0008
// status bit positions of the controller's own events
`define TLIC_EV_TAKE 0
`define TLIC_EV_WAKE 1
`define TLIC_EV_EXT1_EDGE 2

`endif

// ===== design/tlic_ctrl.sv
/*
  two-level interrupt controller: enables, level select, trigger select, fixed polling
  order, nesting and vector call toward the core, idle wake-up and event interrupt.
  assumes a core that takes the call with call_ack_i and signals handler return
  with return_i; internal sources are single-clock-domain levels or pulses.
*/
// The implementer's own choices: the address map and the plain strobed port.
// Summary of operation
// - per-source enable bit gates each request
// - bit 7 is global enable
// - one level bit per source
// - low handler preempted only by high
// - high handler never preempted
// - high level wins over low
// - fixed polling order within a level
// - vector 0003H plus eight per position
// - acknowledge starts long call to vector
// - trigger bit selects low level or edge
// - external one counts both edges
// - enabled request clears the idle flag
`timescale 1ns/1ps
`include "tlic_consts.svh"

module tlic_ctrl (
  input wire logic core_clk_i, // core clock, 10 MHz
  input wire logic reset_i, // synchronous reset, active high
  input wire tlic_pkg::tlic_reg_req_t reg_req_i, // register port request
  output logic [7:0] reg_rdata_o, // read data, cycle after read strobe
  input wire logic external_input_zero_i, // external pin 0, async
  input wire logic external_input_one_i, // external pin 1, async
  input wire logic timer0_source_i, // timer 0 overflow level
  input wire logic timer1_source_i, // timer 1 overflow level
  input wire logic caption_source_i, // caption data ready level
  input wire logic serial_bus_source_i, // serial port level
  input wire logic display_blank_source_i, // display busy level
  input wire logic idle_set_i, // core enters idle
  output logic idle_flag_o, // idle state flag
  output tlic_pkg::tlic_call_t long_subroutine_call_o, // call request to core
  input wire logic call_ack_i, // core takes the call this cycle
  input wire logic return_i, // core ends the current handler
  output logic irq_o // event interrupt, level
);

  localparam int NSRC = `TLIC_NSRC;

  logic [7:0] source_enable_register_r;
  logic [7:0] level_select_register_r;
  logic [7:0] timer_control_register_r;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] mask_r;
  logic [1:0] svc_r;
  logic [1:0] svc_nxt;
  logic idle_flag_r;
  logic [7:0] rdata_r;
  tlic_pkg::tlic_call_t call_r;

  // vector for polling position; used only by the call
  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    vec_of = `TLIC_VEC_BASE + ({13'h0000, idx} << 3);
  endfunction : vec_of

  // lowest index set wins: the fixed polling order
  function automatic logic [2:0] first_of(input logic [NSRC-1:0] v);
    first_of = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_of = i[2:0];
      end
    end
  endfunction : first_of

  wire ext0_edge_mode = timer_control_register_r[`TLIC_EXT0_TRIG_BIT];
  wire ext1_edge_mode = timer_control_register_r[`TLIC_EXT1_TRIG_BIT];
  wire take = call_r.valid & call_ack_i;
  wire take_ext0 = take & (call_r.source == 3'h0);
  wire take_ext1 = take & (call_r.source == 3'h2);
  wire ext0_req;
  wire ext1_req;
  wire ext1_edge;

  tlic_ext_detect u_ext0 (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .pin_i(external_input_zero_i),
    .edge_mode_i(ext0_edge_mode),
    .both_edges_i(1'b0),
    .clear_i(take_ext0),
    .req_o(ext0_req),
    .edge_o()
  );

  tlic_ext_detect u_ext1 (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .pin_i(external_input_one_i),
    .edge_mode_i(ext1_edge_mode),
    .both_edges_i(1'b1),
    .clear_i(take_ext1),
    .req_o(ext1_req),
    .edge_o(ext1_edge)
  );

  // polling order: ext0, timer0, ext1, timer1, caption, serial, display
  wire [NSRC-1:0] raw_req = {display_blank_source_i, serial_bus_source_i,
    caption_source_i, timer1_source_i, ext1_req, timer0_source_i, ext0_req};
  wire global_en = source_enable_register_r[`TLIC_GLOBAL_EN_BIT];
  wire [NSRC-1:0] en_req = raw_req & source_enable_register_r[NSRC-1:0]
    & {NSRC{global_en}};
  wire [NSRC-1:0] hi_req = en_req & level_select_register_r[NSRC-1:0];
  wire [NSRC-1:0] lo_req = en_req & ~level_select_register_r[NSRC-1:0];
  wire in_high = svc_r[1];
  wire in_low = svc_r[0];
  // high blocks all; low admits only high
  wire hi_ok = ~in_high & (|hi_req);
  wire lo_ok = ~in_high & ~in_low & (|lo_req);
  wire pick_high = hi_ok;
  wire [2:0] pick_idx = pick_high ? first_of(hi_req) : first_of(lo_req);
  wire pick_valid = hi_ok | lo_ok;

  // status events; a held call is withdrawn if its request vanishes
  wire [2:0] events;
  assign events[`TLIC_EV_TAKE] = take;
  assign events[`TLIC_EV_WAKE] = idle_flag_r & (|en_req);
  assign events[`TLIC_EV_EXT1_EDGE] = ext1_edge;

  // nesting: the most recent level ends first on return
  always_comb begin
    svc_nxt = svc_r;
    if (return_i) begin
      if (svc_r[1]) begin
        svc_nxt[1] = 1'b0;
      end else begin
        svc_nxt[0] = 1'b0;
      end
    end
    if (take) begin
      if (call_r.high) begin
        svc_nxt[1] = 1'b1;
      end else begin
        svc_nxt[0] = 1'b1;
      end
    end
  end

  wire wr_status = reg_req_i.wr & (reg_req_i.addr == `TLIC_OFF_STATUS);
  // write one clears; a new event in the same cycle wins
  assign status_nxt = events | (status_r & ~(wr_status ? reg_req_i.wdata[2:0] : 3'h0));

  wire wr_en = reg_req_i.wr & (reg_req_i.addr == `TLIC_OFF_SOURCE_EN);
  wire wr_lvl = reg_req_i.wr & (reg_req_i.addr == `TLIC_OFF_LEVEL_SEL);
  wire wr_timer_control_register = reg_req_i.wr & (reg_req_i.addr == `TLIC_OFF_TIMER_CTL);
  wire wr_mask = reg_req_i.wr & (reg_req_i.addr == `TLIC_OFF_MASK);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      source_enable_register_r <= `TLIC_RST_SOURCE_EN;
      level_select_register_r <= `TLIC_RST_LEVEL_SEL;
      timer_control_register_r <= `TLIC_RST_TIMER_CTL;
      mask_r <= 3'(`TLIC_RST_MASK);
    end else begin
      if (wr_en) begin
        source_enable_register_r <= reg_req_i.wdata;
      end
      if (wr_lvl) begin
        level_select_register_r <= {1'b0, reg_req_i.wdata[6:0]};
      end
      if (wr_timer_control_register) begin
        timer_control_register_r <= reg_req_i.wdata;
      end
      if (wr_mask) begin
        mask_r <= reg_req_i.wdata[2:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_r <= 3'h0;
      svc_r <= 2'b00;
      idle_flag_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      svc_r <= svc_nxt;
      if (|en_req) begin
        idle_flag_r <= 1'b0;
      end else if (idle_set_i) begin
        idle_flag_r <= 1'b1;
      end
    end
  end

  // call is re-evaluated each cycle until the core takes it
  always_ff @(posedge core_clk_i) begin
    if (reset_i || take) begin
      call_r <= '0;
    end else begin
      call_r.valid <= pick_valid;
      call_r.high <= pick_high;
      call_r.source <= pick_idx;
      call_r.vector <= vec_of(pick_idx);
    end
  end

  wire [7:0] rd_mux =
    (reg_req_i.addr == `TLIC_OFF_SOURCE_EN) ? source_enable_register_r :
    (reg_req_i.addr == `TLIC_OFF_LEVEL_SEL) ? level_select_register_r :
    (reg_req_i.addr == `TLIC_OFF_TIMER_CTL) ? timer_control_register_r :
    (reg_req_i.addr == `TLIC_OFF_STATUS) ? {5'h00, status_r} :
    (reg_req_i.addr == `TLIC_OFF_MASK) ? {5'h00, mask_r} :
    (reg_req_i.addr == `TLIC_OFF_SERVICE) ? {6'h00, svc_r} :
    (reg_req_i.addr == `TLIC_OFF_IDLE) ? {7'h00, idle_flag_r} : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_req_i.rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign long_subroutine_call_o = call_r;
  assign idle_flag_o = idle_flag_r;
  assign irq_o = |(status_r & mask_r);

endmodule : tlic_ctrl

// ===== design/tlic_ext_detect.sv
/*
  external input conditioner: two-flop synchroniser, level or edge detection and a
  pending latch for edge requests. assumes asynchronous pins and the core clock.
*/
`timescale 1ns/1ps
`include "tlic_consts.svh"

module tlic_ext_detect (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic pin_i, // asynchronous external pin
  input wire logic edge_mode_i, // 1 = edge triggered
  input wire logic both_edges_i, // 1 = rising and falling both count
  input wire logic clear_i, // vector call taken for this source
  output logic req_o, // request toward the arbiter
  output logic edge_o // one-cycle pulse on a counted edge
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pend_r;
  logic pend_nxt;
  wire fall = prev_r & ~sync2_r;
  wire rise = ~prev_r & sync2_r;
  wire hit = fall | (both_edges_i & rise);

  // set wins over the clear so an edge in the call cycle is not lost
  assign pend_nxt = hit | (pend_r & ~clear_i);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
      pend_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      pend_r <= edge_mode_i ? pend_nxt : 1'b0;
    end
  end

  assign req_o = edge_mode_i ? pend_r : ~sync2_r;
  assign edge_o = edge_mode_i & hit;

endmodule : tlic_ext_detect

// ===== design/tlic_pkg.sv
/*
  types for the two-level interrupt controller.
  assumes tlic_consts.svh is compiled alongside.
*/
package tlic_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tlic_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [2:0] source;
    logic high;
  } tlic_call_t;

  typedef enum logic [1:0] {
    TLIC_SVC_NONE = 2'b00,
    TLIC_SVC_LOW = 2'b01,
    TLIC_SVC_HIGH = 2'b10,
    TLIC_SVC_BOTH = 2'b11
  } tlic_svc_t;

endpackage : tlic_pkg

// ===== testbench/tlic_core_model.sv
/*
  core model: takes a presented call after a chosen delay.
  assumes the call struct of tlic_pkg and one clock.
*/
`timescale 1ns/1ps
module tlic_core_model (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // sync reset
  input wire tlic_pkg::tlic_call_t call_i, // presented call
  input wire logic go_i, // accept calls
  input wire logic [1:0] dly_i, // cycles before take
  output logic ack_o // take pulse
);
  logic [1:0] wait_r;
  // ack only while valid, and never twice for one call
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !call_i.valid || ack_o) begin
      wait_r <= 2'h0;
      ack_o <= 1'b0;
    end else if (go_i && wait_r >= dly_i) begin
      ack_o <= 1'b1;
    end else if (wait_r != 2'h3) begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : tlic_core_model

// ===== testbench/tlic_ctrl_chk.sv
/*
  checker for tlic_ctrl: call port, nesting and register reads.
  assumes binding onto tlic_ctrl in one clock domain.
*/
`timescale 1ns/1ps
module tlic_ctrl_chk (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // sync reset
  input wire tlic_pkg::tlic_reg_req_t reg_req_i, // register request
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic idle_set_i, // idle entry
  input wire logic idle_flag_o, // idle flag
  input wire tlic_pkg::tlic_call_t long_subroutine_call_o, // call
  input wire logic call_ack_i, // take
  input wire logic return_i // handler end
);
  wire tlic_pkg::tlic_call_t c = long_subroutine_call_o;
  wire logic take = c.valid && call_ack_i;
  logic hi_r;
  logic lo_r;
  // shadow of the service levels, popped high first
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else begin
      hi_r <= take ? c.high : (hi_r && !return_i);
      lo_r <= (take && !c.high) || (lo_r && !(return_i && !hi_r));
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  vec_addr_a: assert property (
    c.valid |-> c.vector == 16'h0003 + {10'h000, c.source, 3'h0})
    else $error("vector does not match source");
  src_range_a: assert property (
    c.valid |-> c.source < 3'h7) else $error("source out of range");
  take_clear_a: assert property (
    take |=> !c.valid) else $error("call still shown after take");
  high_block_a: assert property (
    hi_r |-> !c.valid) else $error("call during high handler");
  low_block_a: assert property (
    lo_r && c.valid |-> c.high) else $error("low call during low handler");
  level_bit7_a: assert property (
    $past(reg_req_i.rd) && $past(reg_req_i.addr) == 4'h1 |-> !reg_rdata_o[7])
    else $error("level bit 7 not zero");
  wake_clear_a: assert property (
    $rose(c.valid) |-> !idle_flag_o) else $error("idle kept with request");
  idle_set_a: assert property (
    $rose(idle_flag_o) |-> $past(idle_set_i)) else $error("idle set without entry");
endmodule : tlic_ctrl_chk

bind tlic_ctrl tlic_ctrl_chk i_chk (.core_clk_i, .reset_i, .reg_req_i, .reg_rdata_o,
  .idle_set_i, .idle_flag_o, .long_subroutine_call_o, .call_ack_i, .return_i);

// ===== testbench/tlic_ctrl_test.sv
/*
  self-checking bench for tlic_ctrl with a core model.
  assumes design files and the core model compiled first.
*/
`timescale 1ns/1ps
module tlic_ctrl_test;
  typedef struct packed {
    logic [6:0] rq;
    logic [6:0] lv;
    logic [7:0] en;
    logic v;
    logic [2:0] s;
  } tlic_row_t;
  logic clk, rst, idle_flag, ret, go, ack, idle, irq;
  logic [1:0] dly;
  logic [6:0] rq;
  logic [7:0] rdata;
  tlic_pkg::tlic_reg_req_t req;
  tlic_pkg::tlic_call_t call;
  int err_total, comparisons;
  tlic_row_t rows [12];
  // bits of rq in polling order; pins are active low
  tlic_ctrl i_dut (.core_clk_i(clk), .reset_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
    .external_input_zero_i(~rq[0]), .external_input_one_i(~rq[2]),
    .timer0_source_i(rq[1]), .timer1_source_i(rq[3]), .caption_source_i(rq[4]),
    .serial_bus_source_i(rq[5]), .display_blank_source_i(rq[6]), .idle_set_i(idle_flag),
    .idle_flag_o(idle), .long_subroutine_call_o(call), .call_ack_i(ack),
    .return_i(ret), .irq_o(irq));
  tlic_core_model i_core (.core_clk_i(clk), .reset_i(rst), .call_i(call), .go_i(go),
    .dly_i(dly), .ack_o(ack));
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : rd
  task pulse_ret;
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    #1;
  endtask : pulse_ret
  task take(input logic [2:0] s, input logic r);
    int n;
    n = 0;
    while (call.valid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("call valid", 16'h1, {15'h0, call.valid});
    chk("source", {13'h0, s}, {13'h0, call.source});
    while (call.valid === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (r) pulse_ret();
  endtask : take
  task quiet(input int n);
    repeat (n) begin
      tick(1);
      chk("quiet", 16'h0, {15'h0, call.valid});
    end
  endtask : quiet
  task report_and_stop;
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    rq = '0;
    {idle_flag, ret, go, dly} = '0;
    err_total = 0;
    comparisons = 0;
    for (int i = 0; i < 7; i++) rows[i] = '{7'h7f << i, 7'h00, 8'hff, 1'b1, 3'(i)};
    rows[7] = '{7'h41, 7'h40, 8'hff, 1'b1, 3'h6};
    rows[8] = '{7'h7f, 7'h20, 8'hff, 1'b1, 3'h5};
    rows[9] = '{7'h7f, 7'h00, 8'h7f, 1'b0, 3'h0};
    rows[10] = '{7'h01, 7'h00, 8'hfe, 1'b0, 3'h0};
    rows[11] = '{7'h03, 7'h00, 8'hfe, 1'b1, 3'h1};
    tick(10);
    @(posedge clk) rst <= 1'b0;
    foreach (rows[i]) rd(4'(i == 4 ? 15 : i), 8'h00);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h7f);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].en);
      wr(4'h1, {1'b0, rows[i].lv});
      @(posedge clk) rq <= rows[i].rq;
      tick(5);
      chk("valid", {15'h0, rows[i].v}, {15'h0, call.valid});
      if (rows[i].v) begin
        chk("src", {13'h0, rows[i].s}, {13'h0, call.source});
        chk("vec", 16'h0003 + {10'h0, rows[i].s, 3'h0}, call.vector);
        chk("high", {15'h0, rows[i].lv[rows[i].s]}, {15'h0, call.high});
      end
      @(posedge clk) rq <= 7'h00;
      tick(6);
    end
    wr(4'h0, 8'hff);
    wr(4'h1, 8'h28);
    go = 1'b1;
    dly = 2'h2;
    @(posedge clk) rq <= 7'h02;
    take(3'h1, 1'b0);
    @(posedge clk) rq <= 7'h10;
    quiet(6);
    @(posedge clk) rq <= 7'h18;
    take(3'h3, 1'b0);
    @(posedge clk) rq <= 7'h30;
    quiet(6);
    pulse_ret();
    take(3'h5, 1'b0);
    @(posedge clk) rq <= 7'h10;
    pulse_ret();
    quiet(4);
    pulse_ret();
    take(3'h4, 1'b0);
    @(posedge clk) rq <= 7'h00;
    pulse_ret();
    rd(4'h3, 8'h01);
    wr(4'h4, 8'h01);
    chk("irq", 16'h1, {15'h0, irq});
    wr(4'h3, 8'h01);
    chk("irq", 16'h0, {15'h0, irq});
    dly = 2'h0;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h05);
    @(posedge clk) rq <= 7'h04;
    take(3'h2, 1'b1);
    @(posedge clk) rq <= 7'h00;
    take(3'h2, 1'b1);
    rd(4'h3, 8'h05);
    go = 1'b0;
    @(posedge clk) rq <= 7'h01;
    tick(2);
    @(posedge clk) rq <= 7'h00;
    tick(6);
    chk("latched", 16'h1, {15'h0, call.valid});
    go = 1'b1;
    take(3'h0, 1'b1);
    quiet(4);
    go = 1'b0;
    @(posedge clk) idle_flag <= 1'b1;
    @(posedge clk) idle_flag <= 1'b0;
    tick(1);
    chk("idle", 16'h1, {15'h0, idle});
    @(posedge clk) rq <= 7'h02;
    tick(2);
    chk("idle", 16'h0, {15'h0, idle});
    go = 1'b1;
    take(3'h1, 1'b0);
    @(posedge clk) rq <= 7'h00;
    pulse_ret();
    // reset again mid-run: registers, service levels and flags go back to zero
    @(posedge clk) rst <= 1'b1;
    tick(2);
    @(posedge clk) rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h5, 8'h00);
    chk("idle", 16'h0, {15'h0, idle});
    chk("irq", 16'h0, {15'h0, irq});
    chk("valid", 16'h0, {15'h0, call.valid});
    report_and_stop();
  end
endmodule : tlic_ctrl_test
